// >>> logic/acctc_cycle_timer.sv
// down counter that reports when a loaded cycle budget is spent
`timescale 1ns/1ps
`include "acctc_params.svh"
module acctc_cycle_timer (
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  input  wire logic                    load,
  input  wire logic [`ACCTC_CNT_W-1:0] load_value,
  output logic                         expired
);
  logic [`ACCTC_CNT_W-1:0] count_reg;
  logic                    expired_reg;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      count_reg <= `ACCTC_ZERO_CNT;
    end else if (load) begin
      count_reg <= load_value;
    end else if (count_reg != `ACCTC_ZERO_CNT) begin
      count_reg <= count_reg - `ACCTC_ONE_CNT;
    end
  end

  // pulse in the cycle the count reaches zero, so done lands on the budget
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      expired_reg <= 1'b0;
    end else begin
      expired_reg <= !load && (count_reg == `ACCTC_ONE_CNT);
    end
  end

  assign expired = expired_reg;
endmodule

// >>> logic/acctc_params.svh
// constants for the converter calibration and test control block
`ifndef ACCTC_PARAMS_SVH
`define ACCTC_PARAMS_SVH

`define ACCTC_SAMPLE_W      12
`define ACCTC_LANES         8
`define ACCTC_CORES         5
`define ACCTC_CORE_W        3
`define ACCTC_CNT_W         32
`define ACCTC_DEC_W         6
`define ACCTC_DEC_BYPASS    6'h01
`define ACCTC_DEC_4         6'h04
`define ACCTC_DEC_8         6'h08
`define ACCTC_DEC_10        6'h0a
`define ACCTC_DEC_16        6'h10
`define ACCTC_DEC_20        6'h14
`define ACCTC_DEC_32        6'h20
// foreground budgets in sampling clock cycles
`define ACCTC_FG_DEFAULT    32'd102000000
`define ACCTC_FG_LOWSIG     32'd64000000
`define ACCTC_FG_TIM        32'd227000000
`define ACCTC_FG_TIM_LOWSIG 32'd189000000
// background cycle across all cores
`define ACCTC_BG_DEFAULT    32'd816000000
`define ACCTC_BG_LOWSIG     32'd512000000
// code driven while foreground calibration runs (mid scale)
`define ACCTC_CAL_CODE      12'h800
`define ACCTC_TP_FRAME_LEN  5'd5
`define ACCTC_TP_PERIOD     5'd10
`define ACCTC_ONE_CNT       32'h00000001
`define ACCTC_ZERO_CNT      32'h00000000

`endif

// >>> logic/acctc_pattern_gen.sv
// per-lane alternating test pattern source, two frames long
`timescale 1ns/1ps
`include "acctc_params.svh"
module acctc_pattern_gen (
  input  wire logic                                    clk_sys,
  input  wire logic                                    rst_n,
  input  wire logic                                    enable,
  output logic [`ACCTC_LANES*`ACCTC_SAMPLE_W-1:0]      pattern
);
  logic       phase_reg;
  logic [4:0] sid_reg;
  logic [`ACCTC_LANES*`ACCTC_SAMPLE_W-1:0] pattern_next;

  function automatic logic [`ACCTC_SAMPLE_W-1:0] lane_low(input int lane);
    unique case (lane)
      0:       lane_low = 12'h000;
      1:       lane_low = 12'h008;
      2:       lane_low = 12'h010;
      3:       lane_low = 12'h020;
      4:       lane_low = 12'h040;
      5:       lane_low = 12'h100;
      6:       lane_low = 12'h200;
      default: lane_low = 12'h400;
    endcase
  endfunction

  // sample counter spans two frames of five samples
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !enable) begin
      sid_reg   <= 5'd0;
      phase_reg <= 1'b0;
    end else begin
      phase_reg <= !phase_reg;
      if (sid_reg == `ACCTC_TP_PERIOD - 5'd1) begin
        sid_reg <= 5'd0;
      end else begin
        sid_reg <= sid_reg + 5'd1;
      end
    end
  end

  // high code is the bitwise complement of the low code
  always_comb begin
    pattern_next = '0;
    for (int l = 0; l < `ACCTC_LANES; l++) begin
      pattern_next[l*`ACCTC_SAMPLE_W +: `ACCTC_SAMPLE_W] =
        phase_reg ? ~lane_low(l) : lane_low(l);
    end
  end

  assign pattern = pattern_next;
endmodule

// >>> logic/acctc_pkg.sv
// types shared by the calibration and test control files
package acctc_pkg;
  typedef enum logic [3:0] {
    ACCTC_IDLE    = 4'b0001,
    ACCTC_FG_CAL  = 4'b0010,
    ACCTC_TIM_CAL = 4'b0100,
    ACCTC_BG_RUN  = 4'b1000
  } acctc_state_t;
endpackage

// >>> logic/acctc_top.sv
// converter mode, calibration sequencing and test pattern control
`timescale 1ns/1ps
`include "acctc_params.svh"
module acctc_top (
  input  wire logic                                    clk_sys,
  input  wire logic                                    rst_n,
  input  wire logic                                    foreground_cal_trigger,
  input  wire logic                                    background_cal_select,
  input  wire logic                                    continuous_cal_enable,
  input  wire logic                                    low_signal_cal_option,
  input  wire logic                                    timing_cal_enable,
  input  wire logic                                    test_pattern_enable,
  input  wire logic [`ACCTC_DEC_W-1:0]                 decimation,
  input  wire logic [`ACCTC_SAMPLE_W-1:0]              offset_adjust,
  input  wire logic                                    ila_phase,
  input  wire logic                                    sync_n,
  input  wire logic [`ACCTC_LANES*`ACCTC_SAMPLE_W-1:0] conv_data,
  output logic [`ACCTC_LANES*`ACCTC_SAMPLE_W-1:0]      lane_data,
  output logic                                         lane_valid,
  output logic                                         complex_mode,
  output logic                                         decim_error,
  output logic                                         nco_phase_clear,
  output logic                                         trigger_readback,
  output logic                                         cal_busy,
  output logic                                         timing_cal_active,
  output logic [`ACCTC_CORES-1:0]                      core_power,
  output logic [`ACCTC_CORE_W-1:0]                     core_offline,
  output logic [`ACCTC_SAMPLE_W-1:0]                   offset_applied,
  output logic                                         sync_request
);
  acctc_pkg::acctc_state_t state_reg;
  acctc_pkg::acctc_state_t state_next;

  logic [`ACCTC_LANES*`ACCTC_SAMPLE_W-1:0] lane_data_reg;
  logic [`ACCTC_LANES*`ACCTC_SAMPLE_W-1:0] pattern;
  logic [`ACCTC_CNT_W-1:0]                 timer_value;
  logic [`ACCTC_CNT_W-1:0]                 bg_slot;
  logic [`ACCTC_CNT_W-1:0]                 bg_count_reg;
  logic [`ACCTC_CORE_W-1:0]                core_offline_reg;
  logic [`ACCTC_SAMPLE_W-1:0]              offset_applied_reg;
  logic [`ACCTC_DEC_W-1:0]                 dec_count_reg;
  logic [2:0] trig_sync_reg;
  logic [2:0] sync_sync_reg;
  logic       trig_level_reg;
  logic       sync_level_reg;
  logic       trig_prev_reg;
  logic       pending_reg;
  logic       timer_load;
  logic       timer_done;
  logic       lane_valid_reg;
  logic       complex_reg;
  logic       decim_error_reg;
  logic       nco_clear_reg;
  logic       readback_reg;
  logic       busy_reg;
  logic       tim_active_reg;
  logic       trig_rise;
  logic       bg_enabled;
  logic       dec_ok;

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic dec_legal(input logic [`ACCTC_DEC_W-1:0] d);
    dec_legal = (d == `ACCTC_DEC_BYPASS) || (d == `ACCTC_DEC_4) ||
                (d == `ACCTC_DEC_8) || (d == `ACCTC_DEC_10) ||
                (d == `ACCTC_DEC_16) || (d == `ACCTC_DEC_20) ||
                (d == `ACCTC_DEC_32);
  endfunction

  function automatic logic [`ACCTC_CNT_W-1:0] fg_budget(input logic tim,
                                                        input logic low);
    if (tim) begin
      fg_budget = low ? `ACCTC_FG_TIM_LOWSIG : `ACCTC_FG_TIM;
    end else begin
      fg_budget = low ? `ACCTC_FG_LOWSIG : `ACCTC_FG_DEFAULT;
    end
  endfunction

  assign bg_enabled = background_cal_select && continuous_cal_enable;
  assign dec_ok     = dec_legal(decimation);
  // one slot per core; the full rotation equals the fixed cycle
  assign bg_slot    = (low_signal_cal_option ? `ACCTC_BG_LOWSIG
                       : `ACCTC_BG_DEFAULT) / `ACCTC_CORES;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: third and second stage must agree before a change

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      trig_sync_reg <= 3'b000;
      sync_sync_reg <= 3'b111;
    end else begin
      trig_sync_reg <= {trig_sync_reg[1:0], foreground_cal_trigger};
      sync_sync_reg <= {sync_sync_reg[1:0], sync_n};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      trig_level_reg <= 1'b0;
      sync_level_reg <= 1'b1;
    end else begin
      if (trig_sync_reg[2] == trig_sync_reg[1]) begin
        trig_level_reg <= trig_sync_reg[2];
      end
      if (sync_sync_reg[2] == sync_sync_reg[1]) begin
        sync_level_reg <= sync_sync_reg[2];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      trig_prev_reg <= 1'b0;
    end else begin
      trig_prev_reg <= trig_level_reg;
    end
  end

  assign trig_rise = trig_level_reg && !trig_prev_reg;

  // low on the sync input is a request for resynchronisation
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sync_request <= 1'b0;
    end else begin
      sync_request <= !sync_level_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trigger capture; a new write wins over the clear from acceptance

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pending_reg <= 1'b0;
    end else if (trig_rise) begin
      pending_reg <= 1'b1;
    end else if (state_reg == acctc_pkg::ACCTC_IDLE ||
                 state_reg == acctc_pkg::ACCTC_BG_RUN) begin
      pending_reg <= 1'b0;
    end
  end

  // reads as one only while a request waits during the foreground or timing calibration
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      readback_reg <= 1'b0;
    end else begin
      readback_reg <= pending_reg && state_reg != acctc_pkg::ACCTC_IDLE &&
                      state_reg != acctc_pkg::ACCTC_BG_RUN;
    end
  end
  assign trigger_readback = readback_reg;

  ////////////////////////////////////////////////////////////////////////////
  // calibration sequencer

  always_comb begin
    state_next  = state_reg;
    timer_load  = 1'b0;
    timer_value = fg_budget(1'b0, low_signal_cal_option);
    unique case (state_reg)
      acctc_pkg::ACCTC_IDLE, acctc_pkg::ACCTC_BG_RUN: begin
        if (pending_reg) begin
          state_next  = acctc_pkg::ACCTC_FG_CAL;
          timer_load  = 1'b1;
          timer_value = fg_budget(1'b0, low_signal_cal_option);
        end
      end
      acctc_pkg::ACCTC_FG_CAL: begin
        if (timer_done) begin
          if (timing_cal_enable) begin
            // timing pass takes the remainder of the longer budget
            state_next  = acctc_pkg::ACCTC_TIM_CAL;
            timer_load  = 1'b1;
            timer_value = fg_budget(1'b1, low_signal_cal_option) -
                          fg_budget(1'b0, low_signal_cal_option);
          end else if (bg_enabled) begin
            state_next = acctc_pkg::ACCTC_BG_RUN;
          end else begin
            state_next = acctc_pkg::ACCTC_IDLE;
          end
        end
      end
      acctc_pkg::ACCTC_TIM_CAL: begin
        if (timer_done) begin
          state_next = bg_enabled ? acctc_pkg::ACCTC_BG_RUN
                                  : acctc_pkg::ACCTC_IDLE;
        end
      end
      default: state_next = acctc_pkg::ACCTC_IDLE;
    endcase
    if (state_reg == acctc_pkg::ACCTC_BG_RUN && !bg_enabled &&
        !pending_reg) begin
      state_next = acctc_pkg::ACCTC_IDLE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg <= acctc_pkg::ACCTC_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  acctc_cycle_timer u_timer (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .load       (timer_load),
    .load_value (timer_value),
    .expired    (timer_done)
  );

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      busy_reg       <= 1'b0;
      tim_active_reg <= 1'b0;
    end else begin
      busy_reg       <= (state_next == acctc_pkg::ACCTC_FG_CAL) ||
                        (state_next == acctc_pkg::ACCTC_TIM_CAL);
      tim_active_reg <= state_next == acctc_pkg::ACCTC_TIM_CAL;
    end
  end
  assign cal_busy          = busy_reg;
  assign timing_cal_active = tim_active_reg;

  ////////////////////////////////////////////////////////////////////////////
  // background core rotation

  always_ff @(posedge clk_sys) begin
    if (!rst_n || state_reg != acctc_pkg::ACCTC_BG_RUN) begin
      bg_count_reg     <= `ACCTC_ZERO_CNT;
      core_offline_reg <= 3'd0;
    end else if (bg_count_reg >= bg_slot - `ACCTC_ONE_CNT) begin
      // one core returns online in the same cycle the next goes offline
      bg_count_reg     <= `ACCTC_ZERO_CNT;
      core_offline_reg <= (core_offline_reg == 3'd4) ? 3'd0
                          : core_offline_reg + 3'd1;
    end else begin
      bg_count_reg <= bg_count_reg + `ACCTC_ONE_CNT;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      core_power <= 5'b01111;
      core_offline <= 3'd4;
    end else if (bg_enabled) begin
      core_power   <= 5'b11111;
      core_offline <= core_offline_reg;
    end else begin
      core_power   <= 5'b01111;
      core_offline <= 3'd4;
    end
  end

  // offset trim is forced off under background calibration
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      offset_applied_reg <= 12'h000;
    end else begin
      offset_applied_reg <= bg_enabled ? 12'h000 : offset_adjust;
    end
  end
  assign offset_applied = offset_applied_reg;

  ////////////////////////////////////////////////////////////////////////////
  // tuning phase clear during lane alignment

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      nco_clear_reg <= 1'b0;
    end else begin
      nco_clear_reg <= ila_phase;
    end
  end
  assign nco_phase_clear = nco_clear_reg;

  ////////////////////////////////////////////////////////////////////////////
  // output data path

  acctc_pattern_gen u_pattern (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .enable  (test_pattern_enable),
    .pattern (pattern)
  );

  // decimation strobe: one valid word per factor, every cycle in bypass
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !dec_ok || decimation == `ACCTC_DEC_BYPASS) begin
      dec_count_reg <= 6'h00;
    end else if (dec_count_reg == decimation - 6'h01) begin
      dec_count_reg <= 6'h00;
    end else begin
      dec_count_reg <= dec_count_reg + 6'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      lane_valid_reg  <= 1'b0;
      complex_reg     <= 1'b0;
      decim_error_reg <= 1'b0;
    end else begin
      decim_error_reg <= !dec_ok;
      complex_reg     <= dec_ok && decimation != `ACCTC_DEC_BYPASS;
      lane_valid_reg  <= dec_ok && (decimation == `ACCTC_DEC_BYPASS ||
                         dec_count_reg == 6'h00);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      lane_data_reg <= '0;
    end else if (state_next == acctc_pkg::ACCTC_FG_CAL ||
                 state_next == acctc_pkg::ACCTC_TIM_CAL) begin
      lane_data_reg <= {`ACCTC_LANES{`ACCTC_CAL_CODE}};
    end else if (test_pattern_enable) begin
      lane_data_reg <= pattern;
    end else begin
      lane_data_reg <= conv_data;
    end
  end

  assign lane_data    = lane_data_reg;
  assign lane_valid   = lane_valid_reg;
  assign complex_mode = complex_reg;
  assign decim_error  = decim_error_reg;
endmodule

// >>> test/acctc_rx_model.sv
// receiver side model: raises sync requests and marks lane alignment
`timescale 1ns/1ps
module acctc_rx_model (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       start,
  input  wire logic [7:0] wait_cycles,
  output logic            sync_n,
  output logic            ila_phase
);
  logic [2:0] lmfc_reg;
  logic [7:0] hold_reg;
  logic [1:0] step_reg;
  ////////////////////////////////////////////////////////////////////////////
  // free running multiframe count, period of eight cycles
  always_ff @(posedge clk_sys) begin
    if (!rst_n) lmfc_reg <= 3'h0;
    else lmfc_reg <= lmfc_reg + 3'h1;
  end
  ////////////////////////////////////////////////////////////////////////////
  // wait_cycles sets a prompt or a slow receiver
  // posedge updates keep clear of the bench's falling-edge start pulse
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      step_reg <= 2'h0;
      hold_reg <= 8'h00;
      sync_n <= 1'b1;
      ila_phase <= 1'b0;
    end else begin
      case (step_reg)
        2'h0: if (start) begin
          step_reg <= 2'h1;
          sync_n <= 1'b0;
          hold_reg <= wait_cycles;
        end
        2'h1: if (hold_reg != 8'h00) hold_reg <= hold_reg - 8'h01;
          else if (lmfc_reg == 3'h7) begin
            sync_n <= 1'b1;
            step_reg <= 2'h2;
          end
        2'h2: if (lmfc_reg == 3'h7) begin
          ila_phase <= 1'b1;
          hold_reg <= 8'h04;
          step_reg <= 2'h3;
        end
        default: if (hold_reg != 8'h00) hold_reg <= hold_reg - 8'h01;
          else begin
            ila_phase <= 1'b0;
            step_reg <= 2'h0;
          end
      endcase
    end
  end
endmodule

// >>> test/acctc_top_assertions.sv
// concurrent checks on the calibration and test control ports
`timescale 1ns/1ps
`include "acctc_params.svh"
module acctc_top_assertions (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        foreground_cal_trigger,
  input wire logic        background_cal_select,
  input wire logic        continuous_cal_enable,
  input wire logic        timing_cal_enable,
  input wire logic        test_pattern_enable,
  input wire logic [5:0]  decimation,
  input wire logic        ila_phase,
  input wire logic        sync_n,
  input wire logic [95:0] conv_data,
  input wire logic [95:0] lane_data,
  input wire logic        lane_valid,
  input wire logic        complex_mode,
  input wire logic        decim_error,
  input wire logic        nco_phase_clear,
  input wire logic        trigger_readback,
  input wire logic        cal_busy,
  input wire logic        timing_cal_active,
  input wire logic [4:0]  core_power,
  input wire logic [2:0]  core_offline,
  input wire logic [11:0] offset_applied,
  input wire logic        sync_request
);
  logic dec_cplx;
  logic bg_on;
  assign dec_cplx = decimation inside {`ACCTC_DEC_4, `ACCTC_DEC_8,
    `ACCTC_DEC_10, `ACCTC_DEC_16, `ACCTC_DEC_20, `ACCTC_DEC_32};
  assign bg_on = background_cal_select && continuous_cal_enable;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  a_phase_clear_delay: assert property (
    1'b1 |=> nco_phase_clear == $past(ila_phase))
    else $error("phase clear does not follow lane alignment");
  a_bypass_raw_data: assert property (
    (decimation == `ACCTC_DEC_BYPASS && !test_pattern_enable && !cal_busy
     && !bg_on && $stable(conv_data))[*3] |-> lane_valid
     && lane_data == conv_data)
    else $error("bypass output differs from conversion words");
  a_complex_legal: assert property (
    dec_cplx[*3] |-> complex_mode && !decim_error)
    else $error("legal factor not in complex mode");
  a_illegal_factor: assert property (
    (!dec_cplx && decimation != `ACCTC_DEC_BYPASS)[*3] |-> decim_error)
    else $error("illegal factor not flagged");
  a_cal_code_out: assert property (
    cal_busy[*2] |-> lane_data == {8{`ACCTC_CAL_CODE}})
    else $error("sample data shown during calibration");
  a_trigger_starts: assert property (
    $rose(foreground_cal_trigger) && !cal_busy && !trigger_readback
    |-> ##[3:8] cal_busy)
    else $error("trigger did not start calibration");
  a_bg_five_cores: assert property (
    bg_on[*2] |-> core_power == 5'h1f)
    else $error("background mode lacks fifth core");
  a_fg_four_cores: assert property (
    (!background_cal_select)[*2] |-> core_power == 5'h0f
    && core_offline == 3'h4)
    else $error("core set wrong outside background mode");
  a_offset_ignored: assert property (
    bg_on[*2] |-> offset_applied == 12'h000)
    else $error("offset applied in background mode");
  a_timing_quiet: assert property (
    (!timing_cal_enable)[*2] |-> !timing_cal_active)
    else $error("timing pass while disabled");
  a_pattern_toggle: assert property (
    (test_pattern_enable && !cal_busy)[*4]
    |-> lane_data[11:0] == ~$past(lane_data[11:0]))
    else $error("pattern does not alternate");
  a_sync_request: assert property (
    (!sync_n)[*6] |-> sync_request)
    else $error("sync request not seen");
  a_accept_clears: assert property (
    $rose(cal_busy) |-> ##[0:2] !trigger_readback)
    else $error("trigger still pending after acceptance");
  c_cal: cover property ($rose(cal_busy));
  c_cplx: cover property (complex_mode && lane_valid);
  c_err: cover property (decim_error);
  c_pat: cover property (test_pattern_enable[*4]);
endmodule
bind acctc_top acctc_top_assertions acctc_top_assertions_i (
  .clk_sys(clk_sys), .rst_n(rst_n),
  .foreground_cal_trigger(foreground_cal_trigger),
  .background_cal_select(background_cal_select),
  .continuous_cal_enable(continuous_cal_enable),
  .timing_cal_enable(timing_cal_enable),
  .test_pattern_enable(test_pattern_enable), .decimation(decimation),
  .ila_phase(ila_phase), .sync_n(sync_n), .conv_data(conv_data),
  .lane_data(lane_data), .lane_valid(lane_valid),
  .complex_mode(complex_mode), .decim_error(decim_error),
  .nco_phase_clear(nco_phase_clear), .trigger_readback(trigger_readback),
  .cal_busy(cal_busy), .timing_cal_active(timing_cal_active),
  .core_power(core_power), .core_offline(core_offline),
  .offset_applied(offset_applied), .sync_request(sync_request));

// >>> test/tb.sv
// self-checking bench for the calibration and test control block
`timescale 1ns/1ps
`include "acctc_params.svh"
module tb;
  logic clk_sys, rst_n, trig, bg_sel, cont, low_sig, tim_en, pat_en;
  logic [5:0] dec;
  logic [11:0] offs;
  logic [95:0] conv, lane_data, exp_bus;
  logic ila, sync_n, rx_start, ph;
  logic lane_valid, cplx, derr, nco_clr, trig_rb, busy, tim_act, sync_req;
  logic [4:0] core_power;
  logic [2:0] core_offline;
  logic [11:0] offs_app;
  logic [5:0] dec_tab [6];
  logic [11:0] low_tab [8];
  int mismatches, compares, i, k, cnt;
  acctc_rx_model acctc_rx_model_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .start(rx_start), .wait_cycles(8'h0a), .sync_n(sync_n),
    .ila_phase(ila));
  acctc_top acctc_top_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .foreground_cal_trigger(trig), .background_cal_select(bg_sel),
    .continuous_cal_enable(cont), .low_signal_cal_option(low_sig),
    .timing_cal_enable(tim_en), .test_pattern_enable(pat_en),
    .decimation(dec), .offset_adjust(offs), .ila_phase(ila),
    .sync_n(sync_n), .conv_data(conv), .lane_data(lane_data),
    .lane_valid(lane_valid), .complex_mode(cplx), .decim_error(derr),
    .nco_phase_clear(nco_clr), .trigger_readback(trig_rb),
    .cal_busy(busy), .timing_cal_active(tim_act),
    .core_power(core_power), .core_offline(core_offline),
    .offset_applied(offs_app), .sync_request(sync_req));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check_bus(input logic [95:0] got, input logic [95:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic check_flag(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // tests need under 3000 cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    end_of_test();
  end
  initial begin
    {rst_n, trig, bg_sel, cont, low_sig, tim_en, pat_en, rx_start} = '0;
    dec = `ACCTC_DEC_BYPASS;
    offs = 12'h123;
    conv = 96'h123456789abcdef012345678;
    dec_tab = '{`ACCTC_DEC_4, `ACCTC_DEC_8, `ACCTC_DEC_10, `ACCTC_DEC_16,
      `ACCTC_DEC_20, `ACCTC_DEC_32};
    low_tab = '{12'h000, 12'h008, 12'h010, 12'h020, 12'h040, 12'h100,
      12'h200, 12'h400};
    mismatches = 0;
    compares = 0;
    tick(15);
    check_bus(96'(core_power), 96'h0f);
    check_bus(96'(core_offline), 96'h4);
    check_flag(tim_act, 1'b0);
    tick(1);
    rst_n = 1'b1;
    tick(4);
    check_bus(lane_data, conv);
    check_flag(lane_valid, 1'b1);
    check_flag(cplx, 1'b0);
    check_bus(96'(offs_app), 96'h123);
    for (i = 0; i < 6; i++) begin
      dec = dec_tab[i];
      tick(4);
      cnt = 0;
      for (k = 0; k < 4 * dec_tab[i]; k++) begin
        tick(1);
        if (lane_valid === 1'b1) cnt++;
      end
      check_bus(96'(cnt), 96'd4);
      check_flag(cplx, 1'b1);
    end
    dec = 6'h02;
    tick(4);
    check_flag(derr, 1'b1);
    dec = `ACCTC_DEC_BYPASS;
    // select and continuous come before any trigger
    {bg_sel, cont} = 2'b11;
    tick(4);
    check_bus(96'(offs_app), 96'h000);
    check_bus(96'(core_power), 96'h1f);
    {bg_sel, cont} = 2'b00;
    rx_start = 1'b1;
    tick(1);
    rx_start = 1'b0;
    tick(6);
    check_flag(sync_req, 1'b1);
    for (k = 0; k < 100 && ila !== 1'b1; k++) tick(1);
    tick(1);
    check_flag(nco_clr, 1'b1);
    check_flag(sync_req, 1'b0);
    pat_en = 1'b1;
    tick(4);
    ph = (lane_data[11:0] === 12'h000);
    for (k = 0; k < 10; k++) begin
      for (i = 0; i < 8; i++) begin
        exp_bus[12*i +: 12] = ph ? low_tab[i] : ~low_tab[i];
      end
      check_bus(lane_data, exp_bus);
      ph = !ph;
      tick(1);
    end
    pat_en = 1'b0;
    tim_en = 1'b1;
    tick(4);
    trig = 1'b1;
    for (k = 0; k < 20 && busy !== 1'b1; k++) tick(1);
    check_flag(busy, 1'b1);
    tick(2);
    check_bus(lane_data, {8{`ACCTC_CAL_CODE}});
    check_flag(trig_rb, 1'b0);
    trig = 1'b0;
    tick(2);
    // a trigger during calibration waits instead of restarting it
    trig = 1'b1;
    tick(8);
    check_flag(trig_rb, 1'b1);
    check_flag(busy, 1'b1);
    // the host restarts the link after a calibration trigger
    rx_start = 1'b1;
    tick(1);
    rx_start = 1'b0;
    tick(6);
    check_flag(sync_req, 1'b1);
    end_of_test();
  end
endmodule
